// File: logic/ldc_pkg.sv
/*
 * ldc_pkg: constants, field layouts and carrier types of the LCD display
 * control and hard-fill register block.
 * Assumes a 100 MHz system clock and an AXI4-Lite master with 32-bit data.
 */
// Functional notes
// - writing 1 requests SDRAM self-refresh, writing 0 returns it to normal
// - vertical and horizontal flip bits drive the orientation outputs unchanged
// - backlight bit 0 drives enable high and forces PWM low; 1 drives enable low
// - colour-depth bit 0 selects paletted two-page mode, 1 selects direct 16-bit colour
// - two independent blink enables; the second blink toggles faster than the first
// - blink periods are about one second and about half a second
// - transparency shows background through foreground, paletted mode only
// - background page code 00 selects page 0, 01 page 1, others invalid
// - foreground page code 00 selects page 0, 01 page 1, others invalid
// - paletted mode writes and fills go to the write page selected, others invalid
// - direct colour mode writes both pages and ignores the write page field
// - any write to the fill command register starts a hard fill
// - fill colour is palette entry in paletted mode, drawing colour in direct mode
// - the fill covers only the selected write area
// - busy bit reads 1 right after a fill command and 0 once complete
// - on fill completion the interrupt output pulses low for about 26.7 us
// - a hard fill starts by itself soon after reset release
package ldc_pkg;

    // ------------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [22:0] IDX_DISPLAY_CONTROL_A  = 23'h7ffffc;
    localparam logic [22:0] IDX_WRITE_PAGE_SELECT  = 23'h7ffffd;
    localparam logic [22:0] IDX_FILL_COMMAND       = 23'h7fffff;
    localparam logic [22:0] IDX_REFRESH_ORIENT_BL  = 23'h7ffffb;

    localparam logic [7:0]  RST_DISPLAY_CONTROL_A  = 8'h00;
    localparam logic [7:0]  RST_WRITE_PAGE_SELECT  = 8'h00;
    localparam logic [7:0]  RST_REFRESH_ORIENT_BL  = 8'h01;

    // field positions in refresh_orientation_backlight; POS_BUSY is the fill command read bit
    localparam int          POS_SLEEP_REQ          = 3;
    localparam int          POS_VFLIP              = 2;
    localparam int          POS_HFLIP              = 1;
    localparam int          POS_BACKLIGHT          = 0;
    localparam int          POS_BUSY               = 0;

    localparam logic [1:0]  PAGE_0                 = 2'h0;
    localparam logic [1:0]  PAGE_1                 = 2'h1;
    localparam logic [1:0]  RESP_OKAY              = 2'h0;
    localparam logic [1:0]  RESP_SLVERR            = 2'h2;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS          = 10;
    localparam int          IRQ_PULSE_NS           = 26700;
    localparam int          IRQ_PULSE_CYCLES       = IRQ_PULSE_NS / CLK_PERIOD_NS;
    localparam int          SLOW_BLINK_MS          = 1000;
    localparam int          SLOW_BLINK_CYCLES      = SLOW_BLINK_MS * 1000000 / CLK_PERIOD_NS;

    localparam int          FB_ADDR_W              = 23;
    localparam int          COLOUR_W               = 16;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       direct_colour;
        logic       fast_blink_enable;
        logic       slow_blink_enable;
        logic       transparency_enable;
        logic [1:0] background_page;
        logic [1:0] foreground_page;
    } ldc_dca_t;

    typedef struct packed {
        logic [FB_ADDR_W-1:0] addr;
        logic [COLOUR_W-1:0]  data;
        logic [1:0]           page_mask;
    } ldc_fill_wr_t;

    typedef enum logic [2:0] {
        REG_NONE = 3'h0,
        REG_DCA  = 3'h1,
        REG_WPS  = 3'h2,
        REG_FILL = 3'h3,
        REG_ROB  = 3'h4
    } ldc_reg_t;

    typedef enum logic [2:0] {
        FILL_IDLE = 3'b001,
        FILL_RUN  = 3'b010,
        FILL_DONE = 3'b100
    } ldc_fill_state_t;

endpackage

// File: logic/ldc_display_ctrl.sv
/*
 * ldc_display_ctrl: display control registers and hard-fill engine behind
 * an AXI4-Lite slave.
 * Assumes the write area, drawing colour and palette colour come from
 * neighbouring blocks, and that frame buffer writes may stall via ready.
 */
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module ldc_display_ctrl #(
    parameter int BLINK_PERIOD_CYCLES = ldc_pkg::SLOW_BLINK_CYCLES
) (
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_n_i,
    // axi4-lite slave
    input  wire logic [31:0]                 s_axi_awaddr_i,
    input  wire logic                        s_axi_awvalid_i,
    output logic                             s_axi_awready_o,
    input  wire logic [31:0]                 s_axi_wdata_i,
    input  wire logic [3:0]                  s_axi_wstrb_i,
    input  wire logic                        s_axi_wvalid_i,
    output logic                             s_axi_wready_o,
    output logic [1:0]                       s_axi_bresp_o,
    output logic                             s_axi_bvalid_o,
    input  wire logic                        s_axi_bready_i,
    input  wire logic [31:0]                 s_axi_araddr_i,
    input  wire logic                        s_axi_arvalid_i,
    output logic                             s_axi_arready_o,
    output logic [31:0]                      s_axi_rdata_o,
    output logic [1:0]                       s_axi_rresp_o,
    output logic                             s_axi_rvalid_o,
    input  wire logic                        s_axi_rready_i,
    // display side
    output logic                             sdram_sleep_request_o,
    output logic                             vflip_o,
    output logic                             hflip_o,
    output logic                             backlight_enable_n_out_o,
    input  wire logic                        pwm_raw_i,
    output logic                             pwm_o,
    output ldc_pkg::ldc_dca_t                display_ctrl_o,
    output logic                             transparency_active_o,
    output logic                             slow_blink_phase_o,
    output logic                             fast_blink_phase_o,
    output logic [1:0]                       write_page_mask_o,
    // hard fill
    input  wire logic [ldc_pkg::FB_ADDR_W-1:0] write_area_base_i,
    input  wire logic [ldc_pkg::FB_ADDR_W-1:0] write_area_words_i,
    input  wire logic [ldc_pkg::COLOUR_W-1:0]  draw_colour_i,
    input  wire logic [ldc_pkg::COLOUR_W-1:0]  palette_colour_i,
    output logic                             fill_wr_valid_o,
    input  wire logic                        fill_wr_ready_i,
    output ldc_pkg::ldc_fill_wr_t            fill_wr_o,
    output logic                             fill_busy_o,
    output logic                             fill_done_irq_n_o
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic ldc_pkg::ldc_reg_t reg_sel(input logic [31:0] a);
        ldc_pkg::ldc_reg_t r;
        r = ldc_pkg::REG_NONE;
        if (a[1:0] != 2'h0 || a[31:25] != 7'h00) begin
            r = ldc_pkg::REG_NONE;
        end else if (a[24:2] == ldc_pkg::IDX_DISPLAY_CONTROL_A) begin
            r = ldc_pkg::REG_DCA;
        end else if (a[24:2] == ldc_pkg::IDX_WRITE_PAGE_SELECT) begin
            r = ldc_pkg::REG_WPS;
        end else if (a[24:2] == ldc_pkg::IDX_FILL_COMMAND) begin
            r = ldc_pkg::REG_FILL;
        end else if (a[24:2] == ldc_pkg::IDX_REFRESH_ORIENT_BL) begin
            r = ldc_pkg::REG_ROB;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------------
    logic        aw_held_q;
    logic [31:0] aw_addr_q;
    logic        w_held_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        wr_fire;
    ldc_pkg::ldc_reg_t wr_sel;

    assign s_axi_awready_o = !aw_held_q && !bvalid_q;
    assign s_axi_wready_o  = !w_held_q && !bvalid_q;
    assign wr_fire         = aw_held_q && w_held_q && !bvalid_q;
    assign wr_sel          = reg_sel(aw_addr_q);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 32'h0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata_i;
            w_strb_q <= s_axi_wstrb_i;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid_q <= 1'b0;
            bresp_q  <= ldc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wr_sel == ldc_pkg::REG_NONE) ? ldc_pkg::RESP_SLVERR
                                                       : ldc_pkg::RESP_OKAY;
        end else if (s_axi_bready_i) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o  = bresp_q;

    // ------------------------------------------------------------------
    // registers; only byte lane 0 carries data
    // ------------------------------------------------------------------
    logic [7:0] dca_q;
    logic [7:0] wps_q;
    logic [7:0] rob_q;
    logic       lane0_wr;
    logic       fill_cmd;

    assign lane0_wr = wr_fire && w_strb_q[0];
    assign fill_cmd = wr_fire && (wr_sel == ldc_pkg::REG_FILL);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dca_q <= ldc_pkg::RST_DISPLAY_CONTROL_A;
        end else if (lane0_wr && wr_sel == ldc_pkg::REG_DCA) begin
            dca_q <= w_data_q[7:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wps_q <= ldc_pkg::RST_WRITE_PAGE_SELECT;
        end else if (lane0_wr && wr_sel == ldc_pkg::REG_WPS) begin
            wps_q <= w_data_q[7:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rob_q <= ldc_pkg::RST_REFRESH_ORIENT_BL;
        end else if (lane0_wr && wr_sel == ldc_pkg::REG_ROB) begin
            rob_q <= w_data_q[7:0];
        end
    end

    // ------------------------------------------------------------------
    // read channel: only the fill busy bit is readable
    // ------------------------------------------------------------------
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        busy_q;
    ldc_pkg::ldc_reg_t rd_sel;

    assign s_axi_arready_o = !rvalid_q;
    assign rd_sel          = reg_sel(s_axi_araddr_i);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= ldc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_q <= 1'b1;
            rdata_q  <= 32'h0;
            rresp_q  <= (rd_sel == ldc_pkg::REG_NONE) ? ldc_pkg::RESP_SLVERR
                                                       : ldc_pkg::RESP_OKAY;
            if (rd_sel == ldc_pkg::REG_FILL) begin
                rdata_q[ldc_pkg::POS_BUSY] <= busy_q;
            end
        end else if (s_axi_rready_i) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o  = rdata_q;
    assign s_axi_rresp_o  = rresp_q;

    // ------------------------------------------------------------------
    // display outputs
    // ------------------------------------------------------------------
    ldc_pkg::ldc_dca_t dca;
    logic [1:0]        wp_mask;

    assign dca                      = ldc_pkg::ldc_dca_t'(dca_q);
    assign display_ctrl_o           = dca;
    assign sdram_sleep_request_o    = rob_q[ldc_pkg::POS_SLEEP_REQ];
    assign vflip_o                  = rob_q[ldc_pkg::POS_VFLIP];
    assign hflip_o                  = rob_q[ldc_pkg::POS_HFLIP];
    assign backlight_enable_n_out_o = !rob_q[ldc_pkg::POS_BACKLIGHT];
    assign pwm_o = pwm_raw_i && rob_q[ldc_pkg::POS_BACKLIGHT];
    assign transparency_active_o = dca.transparency_enable && !dca.direct_colour;

    // in paletted mode, invalid write page codes enable neither page, so nothing is written
    always_comb begin
        if (dca.direct_colour) begin
            wp_mask = 2'h3;
        end else if (wps_q[1:0] == ldc_pkg::PAGE_0) begin
            wp_mask = 2'h1;
        end else if (wps_q[1:0] == ldc_pkg::PAGE_1) begin
            wp_mask = 2'h2;
        end else begin
            wp_mask = 2'h0;
        end
    end

    assign write_page_mask_o = wp_mask;

    // ------------------------------------------------------------------
    // blink timing: one counter gives both rates so they stay in phase
    // ------------------------------------------------------------------
    localparam int QUARTER = BLINK_PERIOD_CYCLES / 4;
    logic [31:0] blink_cnt_q;
    logic [1:0]  blink_phase_q;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blink_cnt_q   <= 32'h0;
            blink_phase_q <= 2'h0;
        end else if (blink_cnt_q == 32'(QUARTER - 1)) begin
            blink_cnt_q   <= 32'h0;
            blink_phase_q <= blink_phase_q + 2'h1;
        end else begin
            blink_cnt_q   <= blink_cnt_q + 32'h1;
        end
    end

    assign fast_blink_phase_o = dca.fast_blink_enable && blink_phase_q[0];
    assign slow_blink_phase_o = dca.slow_blink_enable && blink_phase_q[1];

    // ------------------------------------------------------------------
    // hard fill engine
    // ------------------------------------------------------------------
    ldc_pkg::ldc_fill_state_t fill_state_q;
    logic                     start_pend_q;
    logic [ldc_pkg::FB_ADDR_W-1:0] left_q;
    logic [ldc_pkg::FB_ADDR_W-1:0] addr_q;
    logic [15:0]              pulse_cnt_q;
    logic                     beat;

    assign beat = fill_wr_valid_o && fill_wr_ready_i;

    // power-up fill is pending straight out of reset; set wins over clear
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_pend_q <= 1'b1;
        end else if (fill_cmd) begin
            start_pend_q <= 1'b1;
        end else if (fill_state_q == ldc_pkg::FILL_IDLE) begin
            start_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fill_state_q <= ldc_pkg::FILL_IDLE;
            addr_q       <= '0;
            left_q       <= '0;
            pulse_cnt_q  <= 16'h0;
        end else begin
            case (fill_state_q)
                ldc_pkg::FILL_IDLE: begin
                    if (start_pend_q) begin
                        fill_state_q <= ldc_pkg::FILL_RUN;
                        addr_q       <= write_area_base_i;
                        left_q       <= write_area_words_i;
                    end
                end
                ldc_pkg::FILL_RUN: begin
                    if (left_q == '0 || (beat && left_q == 23'h1)) begin
                        fill_state_q <= ldc_pkg::FILL_DONE;
                        pulse_cnt_q  <= 16'h0;
                    end
                    if (beat) begin
                        addr_q <= addr_q + 23'h1;
                        left_q <= left_q - 23'h1;
                    end
                end
                ldc_pkg::FILL_DONE: begin
                    pulse_cnt_q <= pulse_cnt_q + 16'h1;
                    if (pulse_cnt_q == 16'(ldc_pkg::IRQ_PULSE_CYCLES - 1)) begin
                        fill_state_q <= ldc_pkg::FILL_IDLE;
                    end
                end
                default: begin
                    fill_state_q <= ldc_pkg::FILL_IDLE;
                end
            endcase
        end
    end

    // busy rises on the command itself so the next read already sees it
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_q <= 1'b1;
        end else if (fill_cmd) begin
            busy_q <= 1'b1;
        end else if (fill_state_q == ldc_pkg::FILL_RUN &&
                     (left_q == '0 || (beat && left_q == 23'h1))) begin
            busy_q <= 1'b0;
        end else if (fill_state_q == ldc_pkg::FILL_IDLE && start_pend_q) begin
            busy_q <= 1'b1;
        end
    end

    assign fill_busy_o       = busy_q;
    assign fill_done_irq_n_o = (fill_state_q != ldc_pkg::FILL_DONE);
    assign fill_wr_valid_o   = (fill_state_q == ldc_pkg::FILL_RUN) && (left_q != '0);
    assign fill_wr_o.addr    = addr_q;
    assign fill_wr_o.data    = dca.direct_colour ? draw_colour_i : palette_colour_i;
    assign fill_wr_o.page_mask = wp_mask;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    int unsigned low_len_q;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_len_q <= 0;
        end else begin
            low_len_q <= fill_done_irq_n_o ? 0 : low_len_q + 1;
        end
    end
    sequence cmd_write_s;
        fill_cmd;
    endsequence
    sequence busy_seen_s;
        ##1 fill_busy_o;
    endsequence
    sleep_follow_a: assert property (
        $rose(sdram_sleep_request_o) |-> $past(wr_fire) && $past(wr_sel) == ldc_pkg::REG_ROB)
        else $error("sleep request rose without a register write");
    orient_pass_a: assert property ({vflip_o, hflip_o} == {rob_q[2], rob_q[1]})
        else $error("orientation outputs differ from register");
    backlight_off_a: assert property (backlight_enable_n_out_o |-> !pwm_o)
        else $error("pwm active with backlight off");
    page_mask_a: assert property (
        display_ctrl_o.direct_colour |-> write_page_mask_o == 2'h3)
        else $error("direct colour mode not writing both pages");
    fill_start_a: assert property (cmd_write_s |-> busy_seen_s)
        else $error("fill command did not raise busy");
    busy_done_a: assert property ($fell(fill_busy_o) |-> ##1 !fill_done_irq_n_o)
        else $error("busy fell without a completion pulse");
    irq_width_a: assert property (
        $rose(fill_done_irq_n_o) |-> low_len_q == ldc_pkg::IRQ_PULSE_CYCLES)
        else $error("completion pulse width wrong");
    blink_rate_a: assert property (
        $changed(blink_phase_q[1]) |-> $changed(blink_phase_q[0]))
        else $error("slow blink toggled faster than fast blink");
    fill_only_run_a: assert property (fill_wr_valid_o |-> fill_busy_o)
        else $error("fill write issued while not busy");

endmodule

`default_nettype wire

// File: test/ldc_fb_sink.sv
/*
 * ldc_fb_sink: frame buffer write port seen by the fill engine.
 * Assumes one beat is moved at each edge with valid and ready high.
 */
`timescale 1ns/1ps
`default_nettype none
module ldc_fb_sink (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic wr_valid_i,
    output logic      wr_ready_o
);
    logic [2:0] cnt_q;
    // stalls two cycles in eight so the engine has to hold a beat through each stall
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) cnt_q <= 3'h0;
        else cnt_q <= cnt_q + 3'h1;
    end
    assign wr_ready_o = (cnt_q[2:1] != 2'h3);
endmodule
`default_nettype wire

// File: test/tb_lcd_display_control_and_fill.sv
/*
 * tb_lcd_display_control_and_fill: self-checking bench for the display
 * control registers and hard fill, driven over AXI4-Lite.
 * Assumes the fill sink model and the design package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_lcd_display_control_and_fill;
    localparam logic [31:0] A_DCA  = {7'h0, ldc_pkg::IDX_DISPLAY_CONTROL_A, 2'h0};
    localparam logic [31:0] A_WPS  = {7'h0, ldc_pkg::IDX_WRITE_PAGE_SELECT, 2'h0};
    localparam logic [31:0] A_FILL = {7'h0, ldc_pkg::IDX_FILL_COMMAND, 2'h0};
    localparam logic [31:0] A_ROB  = {7'h0, ldc_pkg::IDX_REFRESH_ORIENT_BL, 2'h0};
    logic clk = 1'b0, rst_n, awv, wv, bready, arv, rready, pwm_raw;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic awready, wready, bvalid, arready, rvalid, sleep, vflip, hflip, bl_n, pwm, tr;
    logic fv, fr, busy, irq, fast, slow, fb, sb;
    logic [1:0] bresp, rresp, wmask, wp;
    logic [7:0] r, d, nf, ns;
    logic [15:0] dcol;
    logic [9:0] e;
    ldc_pkg::ldc_dca_t dctl;
    ldc_pkg::ldc_fill_wr_t fw;
    ldc_pkg::ldc_fill_wr_t fq[$];
    logic [9:0] rq[$];
    int n_mismatch = 0, total_checks = 0, irq_cnt = 0, i;
    always #5 clk = ~clk;
    ldc_display_ctrl #(.BLINK_PERIOD_CYCLES(16)) i_ldc_display_ctrl (.sys_clk_i(clk),
        .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .sdram_sleep_request_o(sleep), .vflip_o(vflip), .hflip_o(hflip),
        .backlight_enable_n_out_o(bl_n), .pwm_raw_i(pwm_raw), .pwm_o(pwm),
        .display_ctrl_o(dctl), .transparency_active_o(tr), .slow_blink_phase_o(slow),
        .fast_blink_phase_o(fast), .write_page_mask_o(wmask), .write_area_base_i(23'h100),
        .write_area_words_i(23'h20), .draw_colour_i(dcol), .palette_colour_i(16'h1234),
        .fill_wr_valid_o(fv), .fill_wr_ready_i(fr), .fill_wr_o(fw), .fill_busy_o(busy),
        .fill_done_irq_n_o(irq));
    ldc_fb_sink i_ldc_fb_sink (.sys_clk_i(clk), .rst_n_i(rst_n), .wr_valid_i(fv),
        .wr_ready_o(fr));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [1:0] pmask(input logic dc, input logic [1:0] w);
        return dc ? 2'h3 : (w == 2'h0) ? 2'h1 : (w == 2'h1) ? 2'h2 : 2'h0;
    endfunction
    task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] s);
        total_checks++;
        if (x !== s) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one transfer; each channel is released at the edge that takes it
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v,
                       input logic [9:0] x);
        logic t1, t2, t3, t4;
        @(posedge clk);
        rq.push_back(x);
        if (w) begin awaddr <= a; wdata <= v; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1; end
        else begin araddr <= a; arv <= 1'b1; rready <= 1'b1; end
        do begin
            @(negedge clk);
            t1 = awv && awready; t2 = wv && wready; t3 = arv && arready;
            t4 = (bvalid && bready) || (rvalid && rready);
            @(posedge clk);
            if (t1) awv <= 1'b0;
            if (t2) wv <= 1'b0;
            if (t3) arv <= 1'b0;
            if (t4) begin bready <= 1'b0; rready <= 1'b0; end
        end while (!t4);
    endtask
    task automatic push_fill(input logic [1:0] m, input logic [15:0] c);
        for (int k = 0; k < 32; k++) fq.push_back({23'h100 + k[22:0], c, m});
    endtask
    // host waits for busy to fall and the completion pulse to end
    task automatic idle();
        for (int n = 0; busy && n < 1000; n++) @(negedge clk);
        chk("idle", 0, busy);
        repeat (2680) @(negedge clk);
    endtask
    always @(negedge clk) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            e = rq.pop_front();
            chk("bus", e, bvalid ? {bresp, 8'h00} : {rresp, rdata[7:0]});
        end
        if (fv && fr) chk("beat", fq.pop_front(), fw);
        if (!irq) begin
            irq_cnt++;
            if (irq_cnt == 1) chk("busy", 0, busy);
        end else if (irq_cnt != 0) begin
            chk("irq", 2670, irq_cnt);
            irq_cnt = 0;
        end
    end
    initial begin
        {awv, wv, arv, bready, rready, pwm_raw} = 6'h0;
        {awaddr, wdata, araddr, dcol} = 112'h0;
        rst_n = 1'b0;
        r = 8'h19;
        push_fill(2'h1, 16'h1234);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk);
        chk("boot", 1, busy);
        idle();
        bus(1'b0, A_FILL, 0, 10'h0);
        for (i = 0; i < 16; i++) begin
            r = lfsr(r);
            pwm_raw <= r[0];
            bus(1'b1, A_ROB, i, 10'h0);
            chk("rob", {i[3:1], !i[0], i[0] & r[0]}, {sleep, vflip, hflip, bl_n, pwm});
        end
        for (i = 0; i < 8; i++) begin
            r = lfsr(r);
            d = r;
            r = lfsr(r);
            wp = r[1:0];
            bus(1'b1, A_DCA, d, 10'h0);
            bus(1'b1, A_WPS, wp, 10'h0);
            chk("dca", {d, d[4] & !d[7], pmask(d[7], wp)}, {dctl, tr, wmask});
        end
        bus(1'b1, A_DCA, 8'h60, 10'h0);
        @(negedge clk);
        {fb, sb, nf, ns} = {fast, slow, 16'h0};
        // fast level lasts a quarter period, slow level half a period
        repeat (16) begin
            @(negedge clk);
            nf += {7'h0, fb ^ fast};
            ns += {7'h0, sb ^ slow};
            {fb, sb} = {fast, slow};
        end
        chk("blink", 16'h0402, {nf, ns});
        bus(1'b0, A_DCA, 0, 10'h0);
        bus(1'b0, 32'h0, 0, {ldc_pkg::RESP_SLVERR, 8'h00});
        for (i = 0; i < 2; i++) begin
            d = i ? 8'h00 : 8'h80;
            bus(1'b1, A_DCA, d, 10'h0);
            bus(1'b1, A_WPS, 1, 10'h0);
            r = lfsr(r);
            dcol <= {r, ~r};
            push_fill(pmask(d[7], 2'h1), d[7] ? {r, ~r} : 16'h1234);
            bus(1'b1, A_FILL, r, 10'h0);
            bus(1'b0, A_FILL, 0, 10'h1);
            idle();
        end
        chk("left", 0, fq.size() + rq.size());
        finish_test();
    end
    initial begin
        #300000;
        n_mismatch++;
        finish_test();
    end
endmodule
`default_nettype wire
